// ---- tb/smdw_properties.sv ----
// concurrent checks on the top ports of the sync measurement block
// assumes one clock domain; bound to the top from the bench file
`timescale 1ns/1ps
`default_nettype none
module smdw_properties (
   // clock and reset
   input wire logic        clock,
   input wire logic        nrst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // auto-adjust interface
   input wire logic        cmd_apply_phase,
   input wire logic        cmd_apply_window,
   input wire logic        autoadjust_done,
   input wire logic        autoadjust_in_progress
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   // command register write at the access edge, and its idle form
   sequence cmd_wr;
      psel && penable && pwrite && paddr == 12'h140;
   endsequence
   sequence idle_cmd(logic [2:0] c);
      cmd_wr ##0 (!autoadjust_in_progress && pwdata[2:0] == c);
   endsequence
   sequence no_pulse;
      !cmd_apply_phase && !cmd_apply_window;
   endsequence

   // launch, refusal and busy behaviour of the command engine, then status readback and bad-address refusal
   phase_launch_a:
      assert property (idle_cmd(3'h3) |=> cmd_apply_phase && !cmd_apply_window && autoadjust_in_progress)
      else $error("phase command not launched");
   window_launch_a:
      assert property (idle_cmd(3'h4) |=> cmd_apply_window && !cmd_apply_phase && autoadjust_in_progress)
      else $error("window command not launched");
   reserved_code_a:
      assert property (cmd_wr ##0 (!autoadjust_in_progress && pwdata[2:0] != 3'h3 && pwdata[2:0] != 3'h4)
                       |=> no_pulse ##0 !autoadjust_in_progress)
      else $error("reserved code acted on");
   busy_ignore_a:
      assert property (cmd_wr ##0 autoadjust_in_progress |=> no_pulse)
      else $error("command taken while busy");
   busy_hold_a:
      assert property (autoadjust_in_progress && !autoadjust_done |=> autoadjust_in_progress)
      else $error("busy dropped early");
   busy_clear_a:
      assert property (autoadjust_in_progress && autoadjust_done |=> !autoadjust_in_progress)
      else $error("busy not cleared");
   busy_cause_a:
      assert property ($rose(autoadjust_in_progress) |-> cmd_apply_phase || cmd_apply_window)
      else $error("busy without launch");
   status_read_a:
      assert property (psel && penable && !pwrite && paddr == 12'h144
                       |-> prdata[7] == $past(autoadjust_in_progress))
      else $error("status busy bit wrong");
   bad_addr_a:
      assert property (psel && penable && (paddr < 12'h110 || paddr > 12'h144 || paddr[1:0] != 2'h0)
                       |-> pslverr && prdata == 32'h0)
      else $error("bad address not refused");
endmodule : smdw_properties
`default_nettype wire

// ---- tb/smdw_sync_src.sv ----
// behavioural sync timing source: 32-clock lines, 32-line frames
// assumes the block clock; every output idles low while run is low
`timescale 1ns/1ps
`default_nettype none
module smdw_sync_src #(
   parameter int LINE_CYC    = 32,
   parameter int FRAME_LINES = 32
) (
   // clock and control
   input  wire logic clock,
   input  wire logic run,
   // sync timing
   output logic      horiz_sync_output,
   output logic      vert_sync_output,
   output logic      xtal_en,
   output logic      sof
);
   int pix  = 0;
   int line = 0;

   // raster position, restarted while stopped
   always @(posedge clock)
   begin
      pix <= (!run || pix == LINE_CYC - 1) ? 0 : pix + 1;
      if (!run)
         line <= 0;
      else if (pix == LINE_CYC - 1)
         line <= (line == FRAME_LINES - 1) ? 0 : line + 1;
   end

   // vertical pulse from mid line 0 to mid line 3 holding three line starts
   // short serration inside
   assign vert_sync_output  = run && ((line == 0 && pix >= 16) || line == 1 || line == 2 || (line == 3 && pix < 16))
                              && !(line == 1 && pix >= 20 && pix < 23);
   assign horiz_sync_output = run && pix < 4;
   assign xtal_en           = run;   // crystal tick every clock
   assign sof               = run && line == 0 && pix == 0;
endmodule : smdw_sync_src
`default_nettype wire

// ---- tb/sync_measure_de_window_tb.sv ----
// self-checking bench for the sync measurement and window block
// assumes the sync source model and the property checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module sync_measure_de_window_tb;
   import smdw_pkg::*;
   logic        clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic        autoadjust_done = 0, interlaced = 0, run = 0, rd_err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd_data;
   logic        pready, pslverr, pixel_valid_window, cmd_apply_phase, cmd_apply_window;
   logic        autoadjust_in_progress, horiz_sync_output, vert_sync_output, xtal_en, sof;
   int          num_errors = 0, cmp_count = 0, nph = 0, nwin = 0, win_cnt = 0, c0;
   logic [7:0]  rv [14] = '{0, 0, 0, 0, 8'hF6, 8'h05, 0, 0, 8'h26, 8'h04, 0, 0, 0, 0};
   logic [7:0]  mk [14] = '{0, 0, 0, 8'h03, 8'hFF, 8'h0F, 8'hFF, 8'h03, 8'hFF, 8'h0F, 8'hFF, 8'h03, 8'h07, 0};
   logic [7:0]  wv [8]  = '{0, 5, 0, 10, 0, 6, 0, 4};
   logic [7:0]  me [3]  = '{0, 8'h20, 3};
   logic [11:0] bad [3] = '{12'h000, 12'h14C, 12'h111};

   smdw_top u_dut (
      .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .horiz_sync_output(horiz_sync_output), .vert_sync_output(vert_sync_output), .xtal_en(xtal_en),
      .interlaced(interlaced), .pixel_valid_window(pixel_valid_window), .cmd_apply_phase(cmd_apply_phase),
      .cmd_apply_window(cmd_apply_window), .autoadjust_done(autoadjust_done),
      .autoadjust_in_progress(autoadjust_in_progress)
   );
   smdw_sync_src u_src (
      .clock(clock), .run(run), .horiz_sync_output(horiz_sync_output),
      .vert_sync_output(vert_sync_output), .xtal_en(xtal_en), .sof(sof)
   );

   // 10 MHz clock
   initial forever #50 clock = ~clock;

   // pulse and window activity counters
   always @(posedge clock)
   begin
      nph     <= nph + int'(cmd_apply_phase);
      nwin    <= nwin + int'(cmd_apply_window);
      win_cnt <= win_cnt + int'(pixel_valid_window);
   end

   // one apb transfer; read data and error are taken at the edge that sees pready high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // returns on the edge after a frame start
   task automatic wait_sof;
      do
         @(negedge clock);
      while (sof !== 1'b1);
      @(posedge clock);
   endtask : wait_sof

   task automatic win_check(input int e);
      wait_sof();
      #1;
      c0 = win_cnt;
      wait_sof();
      #1;
      chk("window cycles", 32'(e), 32'(win_cnt - c0));
      @(posedge clock);
   endtask : win_check

   task automatic end_of_test;
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // main sequence
   initial
   begin
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < 14; i++)
      begin
         apb(1'b0, 12'h110 + 12'(4 * i), 32'h0);
         chk("reset value", {24'h0, rv[i]}, rd_data);
         apb(1'b1, 12'h110 + 12'(4 * i), 32'hFF);
         apb(1'b0, 12'h110 + 12'(4 * i), 32'h0);
         chk("field width", {24'h0, mk[i]}, rd_data);
      end
      foreach (bad[i])
      begin
         apb(1'b0, bad[i], 32'h0);
         chk("bad addr data", 32'h0, rd_data);
         chk("bad addr error", 32'h1, {31'h0, rd_err});
      end
      $display("test registers done");
      for (int c = 0; c < 8; c++)
      begin
         apb(1'b1, 12'h140, 32'(c));
         apb(1'b0, 12'h144, 32'h0);
         chk("busy", 32'(c == 3 || c == 4), {31'h0, rd_data[7]});
         if (c == 3 || c == 4)
            apb(1'b1, 12'h140, 32'h4);
         autoadjust_done <= 1'b1;
         @(posedge clock);
         autoadjust_done <= 1'b0;
         apb(1'b0, 12'h144, 32'h0);
         chk("idle", 32'h0, {31'h0, rd_data[7]});
      end
      chk("phase pulses", 32'h1, 32'(nph));
      chk("window pulses", 32'h1, 32'(nwin));
      $display("test commands done");
      for (int i = 0; i < 8; i++)
         apb(1'b1, 12'h11C + 12'(4 * i), {24'h0, wv[i]});
      apb(1'b1, 12'h13C, 32'h0);
      run <= 1'b1;
      repeat (3) wait_sof();
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b0, 12'h110 + 12'(4 * i), 32'h0);
         chk("frame measure", {24'h0, me[i]}, rd_data);
      end
      win_check(40);
      apb(1'b1, 12'h120, 32'd25);
      win_check(28);
      interlaced <= 1'b1;
      repeat (4) wait_sof();
      apb(1'b0, 12'h114, 32'h0);
      chk("interlaced period", 32'h40, rd_data);
      interlaced <= 1'b0;
      for (int m = 1; m < 3; m++)
      begin
         apb(1'b1, 12'h13C, 32'(m));
         repeat (3) wait_sof();
         apb(1'b0, 12'h114, 32'h0);
         chk("unit period", (m == 1) ? 32'h2 : 32'h20, rd_data);
      end
      $display("test measurement done");
      end_of_test();
   end

   // watchdog well beyond the expected run of about 17000 cycles
   initial
   begin
      #4000000;
      num_errors++;
      $display("watchdog expired");
      end_of_test();
   end
endmodule : sync_measure_de_window_tb

bind smdw_top smdw_properties u_prop (
   .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .cmd_apply_phase(cmd_apply_phase),
   .cmd_apply_window(cmd_apply_window), .autoadjust_done(autoadjust_done),
   .autoadjust_in_progress(autoadjust_in_progress)
);
`default_nettype wire

// ---- verilog/smdw_dewin.sv ----
// data-enable window generator referenced to the sync outputs
// assumes sync outputs active high, one pixel per clock
`timescale 1ns/1ps
`default_nettype none
module smdw_dewin (
   // clock and reset
   input  wire logic            clock,
   input  wire logic            nrst,
   // sync
   input  wire logic            horiz_sync_output,
   input  wire logic            vert_sync_output,
   // window settings
   input  smdw_pkg::smdw_win_s  win,
   // window output
   output logic                 pixel_valid_window
);
   import smdw_pkg::*;

   logic        hs_d_reg, hs_d_next;
   logic        vs_d_reg, vs_d_next;
   logic [11:0] pcnt_reg, pcnt_next;
   logic [11:0] lcnt_reg, lcnt_next;
   logic        de_reg, de_next;
   logic        hs_fall, vs_fall, h_act, v_act;
   logic [12:0] p_end, l_end;

   assign pixel_valid_window = de_reg;

   // pixel and line position after the trailing edges
   always_comb
   begin
      hs_d_next = horiz_sync_output;
      vs_d_next = vert_sync_output;
      hs_fall   = hs_d_reg & ~horiz_sync_output;
      vs_fall   = vs_d_reg & ~vert_sync_output;
      pcnt_next = pcnt_reg;
      lcnt_next = lcnt_reg;
      if (hs_fall)
         pcnt_next = 12'h0;
      else if (pcnt_reg != 12'hFFF)
         pcnt_next = 12'(pcnt_reg + 12'h1);
      if (vs_fall)
         lcnt_next = 12'h0;
      else if (hs_fall && lcnt_reg != 12'hFFF)
         lcnt_next = 12'(lcnt_reg + 12'h1);
      // R5 R6 pixel span
      p_end = 13'({3'h0, win.pix_start}) + 13'({1'b0, win.pix_width});
      h_act = ({3'h0, win.pix_start} <= 13'({1'b0, pcnt_reg})) && (13'({1'b0, pcnt_reg}) < p_end);
      // R7 R8 line span
      l_end = 13'({3'h0, win.line_start}) + 13'({1'b0, win.line_count});
      v_act = ({3'h0, win.line_start} <= 13'({1'b0, lcnt_reg})) && (13'({1'b0, lcnt_reg}) < l_end);
      de_next = h_act & v_act;
   end

   // window registers
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         hs_d_reg <= 1'b0;
         vs_d_reg <= 1'b0;
         pcnt_reg <= 12'hFFF;
         lcnt_reg <= 12'hFFF;
         de_reg   <= 1'b0;
      end
      else
      begin
         hs_d_reg <= hs_d_next;
         vs_d_reg <= vs_d_next;
         pcnt_reg <= pcnt_next;
         lcnt_reg <= lcnt_next;
         de_reg   <= de_next;
      end
   end

endmodule : smdw_dewin
`default_nettype wire

// ---- verilog/smdw_pkg.sv ----
// package for the vertical sync measurement and data-enable window block
// assumes a single 10 MHz clock and an APB master with 32-bit data
// Function
// R1 - frame period is 12 bits: 256 times upper nibble plus lower byte
// R2 - units are lines when units bit is 0, 512 crystal periods when 1
// R3 - pulse width is 7 bits, true vertical pulse only, no serrations
// R4 - method bit 1: 0 counts whole horizontal syncs, 1 uses timed lines
// R5 - window starts a 10-bit pixel count after horizontal sync trailing edge
// R6 - window stays active for a 12-bit count of pixels per line
// R7 - first valid line is a 10-bit count after vertical sync trailing edge
// R8 - a 12-bit count of lines per frame is visible
// R9 - a write to the command register while idle launches the opcode in bits 2:0
// R10 - software issues only 011 phase or 100 window; others reserved
// R11 - status bit 7 is high while an adjustment is in progress
// R12 - busy rises the cycle after acceptance; commands while busy are ignored
package smdw_pkg;

   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_FRAME_HI   = 8'h44;
   localparam logic [7:0] IDX_FRAME_LO   = 8'h45;
   localparam logic [7:0] IDX_VWIDTH     = 8'h46;
   localparam logic [7:0] IDX_PSTART_HI  = 8'h47;
   localparam logic [7:0] IDX_PSTART_LO  = 8'h48;
   localparam logic [7:0] IDX_PWIDTH_HI  = 8'h49;
   localparam logic [7:0] IDX_PWIDTH_LO  = 8'h4A;
   localparam logic [7:0] IDX_LSTART_HI  = 8'h4B;
   localparam logic [7:0] IDX_LSTART_LO  = 8'h4C;
   localparam logic [7:0] IDX_LCOUNT_HI  = 8'h4D;
   localparam logic [7:0] IDX_LCOUNT_LO  = 8'h4E;
   localparam logic [7:0] IDX_MCONFIG    = 8'h4F;
   localparam logic [7:0] IDX_CMD        = 8'h50;
   localparam logic [7:0] IDX_STATUS     = 8'h51;

   // reset values
   localparam logic [9:0]  RST_PSTART = 10'h0F6;
   localparam logic [11:0] RST_PWIDTH = 12'h500;
   localparam logic [9:0]  RST_LSTART = 10'h026;
   localparam logic [11:0] RST_LCOUNT = 12'h400;
   localparam logic [1:0]  RST_MCONFIG = 2'h0;
   localparam logic [2:0]  RST_CMD    = 3'h0;

   // field positions
   localparam int CFG_UNITS_BIT = 0;
   localparam int CFG_OLD_BIT   = 1;
   localparam int STAT_BUSY_BIT = 7;

   // opcodes
   localparam logic [2:0] OP_APPLY_PHASE  = 3'h3;
   localparam logic [2:0] OP_APPLY_WINDOW = 3'h4;

   // timing
   localparam int CLK_NS     = 100;
   localparam int XTAL_DIV   = 512;
   localparam int VS_GAP_NS  = 10000;
   localparam int VS_GAP_CYC = (VS_GAP_NS + CLK_NS - 1) / CLK_NS;

   // window settings carried to the window generator
   typedef struct packed {
      logic [9:0]  pix_start;
      logic [11:0] pix_width;
      logic [9:0]  line_start;
      logic [11:0] line_count;
   } smdw_win_s;

   // measurement results
   typedef struct packed {
      logic [11:0] frame_period;
      logic [6:0]  pulse_width;
   } smdw_meas_s;

   // command engine states
   typedef enum logic [1:0] {
      CMD_IDLE = 2'b01,
      CMD_BUSY = 2'b10
   } smdw_cmd_e;

endpackage : smdw_pkg

// ---- verilog/smdw_top.sv ----
// top of the vertical sync measurement and data-enable window block
// holds the APB register file and the auto-adjust command interface
// assumes an APB master on the same 10 MHz clock and synchronous sync inputs
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module smdw_top (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         nrst,
   // apb slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // video timing
   input  wire logic         horiz_sync_output,
   input  wire logic         vert_sync_output,
   input  wire logic         xtal_en,
   input  wire logic         interlaced,
   // window output
   output logic              pixel_valid_window,
   // auto-adjust engine interface
   output logic              cmd_apply_phase,
   output logic              cmd_apply_window,
   input  wire logic         autoadjust_done,
   output logic              autoadjust_in_progress
);
   import smdw_pkg::*;

   // window and configuration registers
   logic [9:0]        pstart_reg, pstart_next;
   logic [11:0]       pwidth_reg, pwidth_next;
   logic [9:0]        lstart_reg, lstart_next;
   logic [11:0]       lcount_reg, lcount_next;
   logic [1:0]        mcfg_reg, mcfg_next;
   logic [2:0]        cmd_reg, cmd_next;

   // command engine
   smdw_cmd_e         state_reg, state_next;
   logic              phase_reg, phase_next;
   logic              window_reg, window_next;

   // bus response
   logic [31:0]       prdata_reg, prdata_next;
   logic              err_reg, err_next;

   // decode
   logic              access;
   logic              wr_en;
   logic              rd_en;
   logic [7:0]        idx;
   logic              idx_ok;
   logic              aligned;
   logic              mapped;
   logic [7:0]        wbyte;
   logic [7:0]        rd_val;
   logic              cmd_write;
   logic              cmd_valid;

   smdw_win_s         win;
   smdw_meas_s        meas;

   // apb ports
   assign pready  = 1'b1;
   assign prdata  = prdata_reg;
   assign pslverr = err_reg;

   // window settings to the generator
   assign win.pix_start  = pstart_reg;
   assign win.pix_width  = pwidth_reg;
   assign win.line_start = lstart_reg;
   assign win.line_count = lcount_reg;

   // engine outputs
   assign cmd_apply_phase        = phase_reg;
   assign cmd_apply_window       = window_reg;
   assign autoadjust_in_progress = (state_reg == CMD_BUSY);

   // measurement of the vertical timing
   smdw_vmeas u_vmeas (
      .clock             (clock),
      .nrst              (nrst),
      .horiz_sync_output (horiz_sync_output),
      .vert_sync_output  (vert_sync_output),
      .xtal_en           (xtal_en),
      .interlaced        (interlaced),
      .units_sel         (mcfg_reg[CFG_UNITS_BIT]),
      .old_mode          (mcfg_reg[CFG_OLD_BIT]),
      .meas              (meas)
   );

   // data-enable window generation
   smdw_dewin u_dewin (
      .clock              (clock),
      .nrst               (nrst),
      .horiz_sync_output  (horiz_sync_output),
      .vert_sync_output   (vert_sync_output),
      .win                (win),
      .pixel_valid_window (pixel_valid_window)
   );

   // address decode, one word per register
   always_comb
   begin
      access  = psel & penable;
      idx     = paddr[9:2];
      aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
      idx_ok  = (idx >= IDX_FRAME_HI) && (idx <= IDX_STATUS);
      mapped  = aligned & idx_ok;
      wr_en   = access & pwrite & mapped;
      rd_en   = psel & ~penable & ~pwrite & mapped;
      wbyte   = pwdata[7:0];
   end

   // read multiplexer, unused bits read as zero
   always_comb
   begin
      rd_val = 8'h0;
      unique case (idx)
         // R1 period split
         IDX_FRAME_HI:  rd_val = {4'h0, meas.frame_period[11:8]};
         IDX_FRAME_LO:  rd_val = meas.frame_period[7:0];
         // R3 width readback
         IDX_VWIDTH:    rd_val = {1'b0, meas.pulse_width};
         IDX_PSTART_HI: rd_val = {6'h0, pstart_reg[9:8]};
         IDX_PSTART_LO: rd_val = pstart_reg[7:0];
         IDX_PWIDTH_HI: rd_val = {4'h0, pwidth_reg[11:8]};
         IDX_PWIDTH_LO: rd_val = pwidth_reg[7:0];
         IDX_LSTART_HI: rd_val = {6'h0, lstart_reg[9:8]};
         IDX_LSTART_LO: rd_val = lstart_reg[7:0];
         IDX_LCOUNT_HI: rd_val = {4'h0, lcount_reg[11:8]};
         IDX_LCOUNT_LO: rd_val = lcount_reg[7:0];
         IDX_MCONFIG:   rd_val = {6'h0, mcfg_reg};
         IDX_CMD:       rd_val = {5'h0, cmd_reg};
         // R11 busy flag
         IDX_STATUS:    rd_val = {autoadjust_in_progress, 7'h0};
         default:       rd_val = 8'h0;
      endcase
   end

   // bus response loaded at the setup edge so it stands through the access cycle
   always_comb
   begin
      prdata_next = 32'h0;
      err_next    = 1'b0;
      if (rd_en)
         prdata_next = {24'h0, rd_val};
      if (psel && !penable && !mapped)
         err_next = 1'b1;
   end

   // register writes
   always_comb
   begin
      pstart_next = pstart_reg;
      pwidth_next = pwidth_reg;
      lstart_next = lstart_reg;
      lcount_next = lcount_reg;
      mcfg_next   = mcfg_reg;
      cmd_next    = cmd_reg;
      if (wr_en)
      begin
         unique case (idx)
            // R5 pixel start
            IDX_PSTART_HI: pstart_next[9:8]  = wbyte[1:0];
            IDX_PSTART_LO: pstart_next[7:0]  = wbyte;
            // R6 pixel width
            IDX_PWIDTH_HI: pwidth_next[11:8] = wbyte[3:0];
            IDX_PWIDTH_LO: pwidth_next[7:0]  = wbyte;
            // R7 line start
            IDX_LSTART_HI: lstart_next[9:8]  = wbyte[1:0];
            IDX_LSTART_LO: lstart_next[7:0]  = wbyte;
            // R8 line count
            IDX_LCOUNT_HI: lcount_next[11:8] = wbyte[3:0];
            IDX_LCOUNT_LO: lcount_next[7:0]  = wbyte;
            // R2 R4 units and method
            IDX_MCONFIG:   mcfg_next         = wbyte[1:0];
            IDX_CMD:       cmd_next          = wbyte[2:0];
            default:       cmd_next          = cmd_reg;
         endcase
      end
   end

   // command launch and busy tracking
   always_comb
   begin
      // R9 write launches
      cmd_write   = wr_en && (idx == IDX_CMD);
      // R10 only two codes valid
      cmd_valid   = (wbyte[2:0] == OP_APPLY_PHASE) || (wbyte[2:0] == OP_APPLY_WINDOW);
      state_next  = state_reg;
      phase_next  = 1'b0;
      window_next = 1'b0;
      unique case (state_reg)
         CMD_IDLE:
         begin
            // R12 accept when idle
            if (cmd_write && cmd_valid)
            begin
               state_next  = CMD_BUSY;
               phase_next  = (wbyte[2:0] == OP_APPLY_PHASE);
               window_next = (wbyte[2:0] == OP_APPLY_WINDOW);
            end
         end
         CMD_BUSY:
         begin
            // R12 ignore until done
            if (autoadjust_done)
               state_next = CMD_IDLE;
         end
         default:
            state_next = CMD_IDLE;
      endcase
   end

   // registers of the whole top
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pstart_reg <= RST_PSTART;
         pwidth_reg <= RST_PWIDTH;
         lstart_reg <= RST_LSTART;
         lcount_reg <= RST_LCOUNT;
         mcfg_reg   <= RST_MCONFIG;
         cmd_reg    <= RST_CMD;
         state_reg  <= CMD_IDLE;
         phase_reg  <= 1'b0;
         window_reg <= 1'b0;
         prdata_reg <= 32'h0;
         err_reg    <= 1'b0;
      end
      else
      begin
         pstart_reg <= pstart_next;
         pwidth_reg <= pwidth_next;
         lstart_reg <= lstart_next;
         lcount_reg <= lcount_next;
         mcfg_reg   <= mcfg_next;
         cmd_reg    <= cmd_next;
         state_reg  <= state_next;
         phase_reg  <= phase_next;
         window_reg <= window_next;
         prdata_reg <= prdata_next;
         err_reg    <= err_next;
      end
   end

endmodule : smdw_top
`default_nettype wire

// ---- verilog/smdw_vmeas.sv ----
// vertical sync period and pulse width measurement
// assumes sync inputs active high and synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module smdw_vmeas (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              nrst,
   // sync and timebase
   input  wire logic              horiz_sync_output,
   input  wire logic              vert_sync_output,
   input  wire logic              xtal_en,
   input  wire logic              interlaced,
   // configuration
   input  wire logic              units_sel,
   input  wire logic              old_mode,
   // results
   output smdw_pkg::smdw_meas_s   meas
);
   import smdw_pkg::*;

   logic              hs_d_reg, hs_d_next;
   logic              vs_d_reg, vs_d_next;
   logic [8:0]        xdiv_reg, xdiv_next;
   logic [15:0]       xline_reg, xline_next;
   logic [15:0]       lper_reg, lper_next;
   logic [15:0]       lel_reg, lel_next;
   logic              vtrue_reg, vtrue_next;
   logic [7:0]        gap_reg, gap_next;
   logic [6:0]        wcnt_reg, wcnt_next;
   logic [11:0]       fcnt_reg, fcnt_next;
   logic              odd_reg, odd_next;
   smdw_meas_s        meas_reg, meas_next;
   logic              hs_rise, vstart, x512, timed_tick, line_tick, unit;

   assign meas = meas_reg;

   // next state of all measurement counters
   always_comb
   begin
      hs_d_next  = horiz_sync_output;
      vs_d_next  = vert_sync_output;
      hs_rise    = horiz_sync_output & ~hs_d_reg;
      vstart     = vert_sync_output & ~vs_d_reg & ~vtrue_reg;
      xdiv_next  = xdiv_reg;
      xline_next = xline_reg;
      lper_next  = lper_reg;
      lel_next   = lel_reg;
      timed_tick = 1'b0;
      // crystal divided by 512
      x512 = xtal_en && (xdiv_reg == 9'(XTAL_DIV - 1));
      if (xtal_en)
         xdiv_next = 9'(xdiv_reg + 9'h1);
      // line period in crystal ticks
      if (hs_rise)
      begin
         lper_next  = xline_reg;
         xline_next = 16'(xtal_en);
      end
      else if (xtal_en && xline_reg != 16'hFFFF)
         xline_next = 16'(xline_reg + 16'h1);
      // R4 timed lines, the leading-edge cycle is the first tick of a line
      if (vstart)
         lel_next = 16'(xtal_en);
      else if (xtal_en && lper_reg != 16'h0)
      begin
         if (16'(lel_reg + 16'h1) >= lper_reg)
         begin
            timed_tick = 1'b1;
            lel_next   = 16'h0;
         end
         else
            lel_next = 16'(lel_reg + 16'h1);
      end
      // R4 method select
      line_tick = old_mode ? timed_tick : hs_rise;
      // R2 unit select
      unit = units_sel ? x512 : line_tick;
      // R3 true pulse, serration gaps bridged
      vtrue_next = vtrue_reg;
      gap_next   = 8'h0;
      wcnt_next  = wcnt_reg;
      meas_next  = meas_reg;
      if (vstart)
      begin
         vtrue_next = 1'b1;
         wcnt_next  = 7'h0;
      end
      else if (vtrue_reg)
      begin
         if (!vert_sync_output)
            gap_next = 8'(gap_reg + 8'h1);
         if (vert_sync_output && unit && wcnt_reg != 7'h7F)
            wcnt_next = 7'(wcnt_reg + 7'h1);
         if (gap_reg == 8'(VS_GAP_CYC - 1))
         begin
            vtrue_next            = 1'b0;
            meas_next.pulse_width = wcnt_reg;
         end
      end
      // R1 frame of one or two fields
      odd_next  = odd_reg;
      fcnt_next = fcnt_reg;
      if (vstart)
      begin
         odd_next = ~odd_reg;
         if (!interlaced || odd_reg)
         begin
            meas_next.frame_period = fcnt_reg;
            fcnt_next              = 12'h0;
         end
      end
      else if (unit && fcnt_reg != 12'hFFF)
         fcnt_next = 12'(fcnt_reg + 12'h1);
   end

   // measurement registers
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         hs_d_reg  <= 1'b0;
         vs_d_reg  <= 1'b0;
         xdiv_reg  <= 9'h0;
         xline_reg <= 16'h0;
         lper_reg  <= 16'h0;
         lel_reg   <= 16'h0;
         vtrue_reg <= 1'b0;
         gap_reg   <= 8'h0;
         wcnt_reg  <= 7'h0;
         fcnt_reg  <= 12'h0;
         odd_reg   <= 1'b0;
         meas_reg  <= '0;
      end
      else
      begin
         hs_d_reg  <= hs_d_next;
         vs_d_reg  <= vs_d_next;
         xdiv_reg  <= xdiv_next;
         xline_reg <= xline_next;
         lper_reg  <= lper_next;
         lel_reg   <= lel_next;
         vtrue_reg <= vtrue_next;
         gap_reg   <= gap_next;
         wcnt_reg  <= wcnt_next;
         fcnt_reg  <= fcnt_next;
         odd_reg   <= odd_next;
         meas_reg  <= meas_next;
      end
   end

endmodule : smdw_vmeas
`default_nettype wire
